//--- mir_far_side.sv
// memory and io bus sink: counts transfers per destination
`timescale 1ns/1ps
`default_nettype none
module mir_far_side (
   // clock and reset
   input  wire logic               clk,
   input  wire logic               rst_n,
   // routed access
   input  wire mir_pkg::mir_route_t route,
   // transfer counts
   output logic [15:0]             n_mem,
   output logic [15:0]             n_io
);
   import mir_pkg::*;
   // every answered access lands on exactly one bus
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         n_mem <= 16'h0;
         n_io  <= 16'h0;
      end else if (route.valid) begin
         n_mem <= n_mem + 16'(route.to_memory);
         n_io  <= n_io + 16'(!route.to_memory);
      end
   end
endmodule : mir_far_side
`default_nettype wire

//--- mir_pair_match.sv
// base/mask hit test for one io range pair
`timescale 1ns/1ps
`default_nettype none
module mir_pair_match (
   // programmed pair
   input  wire logic [mir_pkg::MIR_FIELD_W-1:0]   range_base,
   input  wire logic [mir_pkg::MIR_FIELD_W-1:0]   range_mask,
   input  wire logic                              pair_valid,
   // access address
   input  wire logic [mir_pkg::MIR_ARCH_PA_W-1:0] addr,
   // result
   output logic                                   hit
);
   import mir_pkg::*;

   wire logic [MIR_FIELD_W-1:0] page = addr[MIR_ARCH_PA_W-1:MIR_PAGE_LSB];

   // low 12 address bits never take part in the compare
   assign hit = pair_valid &&
                ((page & range_mask) == (range_base & range_mask));

endmodule : mir_pair_match
`default_nettype wire

//--- mir_pkg.sv
// shared constants, types and helpers for the memory/io range router
package mir_pkg;

   // architectural address space and field positions
   localparam int MIR_ARCH_PA_W   = 52;
   localparam int MIR_PAGE_LSB    = 12;
   localparam int MIR_TOP_LSB     = 23;
   localparam int MIR_FIELD_W     = MIR_ARCH_PA_W - MIR_PAGE_LSB;
   localparam int MIR_TOP_W       = MIR_ARCH_PA_W - MIR_TOP_LSB;
   localparam int MIR_BASE_WR_BIT = 3;
   localparam int MIR_BASE_RD_BIT = 4;
   localparam int MIR_MASK_V_BIT  = 11;
   localparam int MIR_CFG_LOW_BIT = 20;
   localparam int MIR_CFG_HIGH_BIT = 21;
   localparam int MIR_NUM_PAIRS   = 2;

   // register port indices
   localparam int MIR_IDX_W        = 4;
   localparam int MIR_IDX_PAIR0    = 0;
   localparam int MIR_IDX_LOW_TOP  = 4;
   localparam int MIR_IDX_HIGH_TOP = 5;
   localparam int MIR_IDX_SYSTEM_CONFIGURATION_REGISTER   = 6;
   localparam int MIR_NUM_REGS     = 7;

   localparam logic [MIR_ARCH_PA_W-1:0] MIR_FOUR_GIG = 52'h1_0000_0000;

   // memory type codes
   localparam logic [2:0] MIR_MT_UC = 3'h0;
   localparam logic [2:0] MIR_MT_WC = 3'h1;
   localparam logic [2:0] MIR_MT_WT = 3'h4;
   localparam logic [2:0] MIR_MT_WP = 3'h5;
   localparam logic [2:0] MIR_MT_WB = 3'h6;

   typedef enum logic [1:0] {
      MIR_SRC_DEFAULT  = 2'h0,
      MIR_SRC_PAIR     = 2'h1,
      MIR_SRC_LOW_TOP  = 2'h3,
      MIR_SRC_HIGH_TOP = 2'h2
   } mir_src_t;

   typedef struct packed {
      logic                     valid;
      logic                     write;
      logic [MIR_ARCH_PA_W-1:0] addr;
      logic [2:0]               mtype;
   } mir_access_t;

   typedef struct packed {
      logic       valid;
      logic       to_memory;
      mir_src_t   source;
      logic [2:0] mtype;
      logic       combo_reserved;
   } mir_route_t;

   typedef struct packed {
      logic                 req;
      logic                 we;
      logic [MIR_IDX_W-1:0] index;
      logic [63:0]          wdata;
   } mir_msr_req_t;

   typedef struct packed {
      logic        ack;
      logic        err;
      logic [63:0] rdata;
   } mir_msr_rsp_t;

   // allowed read/write routing versus memory type combinations
   function automatic logic mir_combo_ok(input logic rd, input logic wr,
                                          input logic [2:0] mt);
      logic ok;
      ok = 1'b0;
      case ({rd, wr})
         2'h0: ok = (mt == MIR_MT_UC) || (mt == MIR_MT_WC) ||
                    (mt == MIR_MT_WT) || (mt == MIR_MT_WP);
         2'h1: ok = (mt == MIR_MT_UC) || (mt == MIR_MT_WC);
         2'h2: ok = (mt == MIR_MT_UC) || (mt == MIR_MT_WP);
         2'h3: ok = (mt == MIR_MT_UC) || (mt == MIR_MT_WC) ||
                    (mt == MIR_MT_WT) || (mt == MIR_MT_WB);
         default: ok = 1'b0;
      endcase
      return ok;
   endfunction : mir_combo_ok

endpackage : mir_pkg

//--- mir_router.sv
// memory/io range router: io range pairs, top-of-memory, access routing
//
// Overview of operation
// - two io range pairs, 0 and 1, each a base and mask register
// - base bit 3 set sends hitting writes to memory, clear to io
// - base bit 4 set sends hitting reads to memory, clear to io
// - base bits 51:12 give a 4K aligned base, low 12 bits zero
// - mask bits 51:12 give a 4K aligned mask, low bits zero
// - mask bit 11 enables the pair; clear pair never routes
// - all defined fields of both pair registers read and write
// - pair matching works like variable-range memory type registers
// - routing with memory type follows the allowed combination table
// - types 0,1,4,5,6; other combinations flagged reserved
// - low top enabled: address 0 up to below it goes to memory
// - low top enabled: from it up to FFFF_FFFFh goes to io
// - high top enabled: 1_0000_0000h up to below it goes to memory
// - high top enabled: from it to the highest address goes to io
// - top registers keep bits 51:23, an 8M aligned boundary
// - other top register bits ignored; software writes them zero
// - low top acts only while configuration bit 20 is set
// - high top acts only while configuration bit 21 is set
// - disabled top register leaves its region routed to io
// - with the features off every access goes to io
// - 52-bit address space; fewer implemented bits allowed
`timescale 1ns/1ps
`default_nettype none
module mir_router #(
   parameter int PA_W = 52
) (
   // clock and reset
   input  wire logic                  clk,
   input  wire logic                  rst_n,
   // model specific register port
   input  wire mir_pkg::mir_msr_req_t msr_req,
   output mir_pkg::mir_msr_rsp_t      msr_rsp,
   // physical access path
   input  wire mir_pkg::mir_access_t  access,
   output mir_pkg::mir_route_t        route
);
   import mir_pkg::*;

   ////////////////////////////////////////////////////////////////////////
   // parameter check
   generate
      if (PA_W < 33 || PA_W > MIR_ARCH_PA_W) begin : g_bad_pa_w
         $error("PA_W must lie between 33 and 52");
      end
   endgenerate

   // bits above the implemented width are not stored and never match
   localparam logic [MIR_ARCH_PA_W-1:0] IMPL_MASK =
      {MIR_ARCH_PA_W{1'b1}} >> (MIR_ARCH_PA_W - PA_W);
   localparam logic [MIR_FIELD_W-1:0] FIELD_KEEP =
      IMPL_MASK[MIR_ARCH_PA_W-1:MIR_PAGE_LSB];
   localparam logic [MIR_TOP_W-1:0] TOP_KEEP =
      IMPL_MASK[MIR_ARCH_PA_W-1:MIR_TOP_LSB];
   localparam logic [MIR_IDX_W-1:0] IDX_LOW  = MIR_IDX_W'(MIR_IDX_LOW_TOP);
   localparam logic [MIR_IDX_W-1:0] IDX_HIGH = MIR_IDX_W'(MIR_IDX_HIGH_TOP);
   localparam logic [MIR_IDX_W-1:0] IDX_CFG  = MIR_IDX_W'(MIR_IDX_SYSTEM_CONFIGURATION_REGISTER);
   localparam logic [MIR_IDX_W-1:0] IDX_END  = MIR_IDX_W'(MIR_NUM_REGS);

   ////////////////////////////////////////////////////////////////////////
   // register state
   logic [MIR_FIELD_W-1:0] base_r  [MIR_NUM_PAIRS];
   logic [MIR_FIELD_W-1:0] mask_r  [MIR_NUM_PAIRS];
   logic                   rdm_r   [MIR_NUM_PAIRS];
   logic                   wrm_r   [MIR_NUM_PAIRS];
   logic                   valid_r [MIR_NUM_PAIRS];
   logic [MIR_TOP_W-1:0]   low_top_r;
   logic [MIR_TOP_W-1:0]   high_top_r;
   logic                   low_en_r;
   logic                   high_en_r;
   mir_msr_rsp_t           msr_rsp_r;
   mir_route_t             route_r;

   // register decode
   wire logic wr_stb  = msr_req.req && msr_req.we;
   wire logic idx_ok  = msr_req.index < IDX_END;
   wire logic wr_low  = wr_stb && (msr_req.index == IDX_LOW);
   wire logic wr_high = wr_stb && (msr_req.index == IDX_HIGH);
   wire logic wr_cfg  = wr_stb && (msr_req.index == IDX_CFG);
   wire logic [MIR_FIELD_W-1:0] wr_field =
      msr_req.wdata[MIR_ARCH_PA_W-1:MIR_PAGE_LSB] & FIELD_KEEP;
   wire logic [MIR_TOP_W-1:0] wr_top =
      msr_req.wdata[MIR_ARCH_PA_W-1:MIR_TOP_LSB] & TOP_KEEP;

   logic [63:0]            rd_word [MIR_NUM_REGS];
   logic [MIR_NUM_PAIRS-1:0] pair_hit;
   logic [MIR_ARCH_PA_W-1:0] acc_addr;

   assign acc_addr = access.addr & IMPL_MASK;

   ////////////////////////////////////////////////////////////////////////
   // io range pairs
   genvar gi;
   generate
      for (gi = 0; gi < MIR_NUM_PAIRS; gi++) begin : g_pair
         localparam logic [MIR_IDX_W-1:0] IDX_B =
            MIR_IDX_W'(MIR_IDX_PAIR0 + 2 * gi);
         localparam logic [MIR_IDX_W-1:0] IDX_M =
            MIR_IDX_W'(MIR_IDX_PAIR0 + 2 * gi + 1);
         wire logic wr_b = wr_stb && (msr_req.index == IDX_B);
         wire logic wr_m = wr_stb && (msr_req.index == IDX_M);

         always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
               base_r[gi] <= '0;
               rdm_r[gi]  <= 1'b0;
               wrm_r[gi]  <= 1'b0;
            end else if (wr_b) begin
               base_r[gi] <= wr_field;
               rdm_r[gi]  <= msr_req.wdata[MIR_BASE_RD_BIT];
               wrm_r[gi]  <= msr_req.wdata[MIR_BASE_WR_BIT];
            end
         end

         always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
               mask_r[gi]  <= '0;
               valid_r[gi] <= 1'b0;
            end else if (wr_m) begin
               mask_r[gi]  <= wr_field;
               valid_r[gi] <= msr_req.wdata[MIR_MASK_V_BIT];
            end
         end

         // reserved fields read back as zero
         always_comb begin
            rd_word[2 * gi] = '0;
            rd_word[2 * gi][MIR_ARCH_PA_W-1:MIR_PAGE_LSB] = base_r[gi];
            rd_word[2 * gi][MIR_BASE_RD_BIT] = rdm_r[gi];
            rd_word[2 * gi][MIR_BASE_WR_BIT] = wrm_r[gi];
            rd_word[2 * gi + 1] = '0;
            rd_word[2 * gi + 1][MIR_ARCH_PA_W-1:MIR_PAGE_LSB] = mask_r[gi];
            rd_word[2 * gi + 1][MIR_MASK_V_BIT] = valid_r[gi];
         end

         mir_pair_match u_match (
            .range_base (base_r[gi]),
            .range_mask (mask_r[gi]),
            .pair_valid (valid_r[gi]),
            .addr       (acc_addr),
            .hit        (pair_hit[gi])
         );
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////
   // top-of-memory and configuration
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         low_top_r <= '0;
      end else if (wr_low) begin
         low_top_r <= wr_top;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         high_top_r <= '0;
      end else if (wr_high) begin
         high_top_r <= wr_top;
      end
   end

   // only the two enables live here; other configuration bits read zero
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         low_en_r  <= 1'b0;
         high_en_r <= 1'b0;
      end else if (wr_cfg) begin
         low_en_r  <= msr_req.wdata[MIR_CFG_LOW_BIT];
         high_en_r <= msr_req.wdata[MIR_CFG_HIGH_BIT];
      end
   end

   always_comb begin
      rd_word[MIR_IDX_LOW_TOP] = '0;
      rd_word[MIR_IDX_LOW_TOP][MIR_ARCH_PA_W-1:MIR_TOP_LSB] = low_top_r;
      rd_word[MIR_IDX_HIGH_TOP] = '0;
      rd_word[MIR_IDX_HIGH_TOP][MIR_ARCH_PA_W-1:MIR_TOP_LSB] = high_top_r;
      rd_word[MIR_IDX_SYSTEM_CONFIGURATION_REGISTER] = '0;
      rd_word[MIR_IDX_SYSTEM_CONFIGURATION_REGISTER][MIR_CFG_LOW_BIT]  = low_en_r;
      rd_word[MIR_IDX_SYSTEM_CONFIGURATION_REGISTER][MIR_CFG_HIGH_BIT] = high_en_r;
   end

   ////////////////////////////////////////////////////////////////////////
   // register port answer, one cycle after the request
   wire logic [63:0] rd_sel =
      idx_ok ? rd_word[msr_req.index[2:0]] : 64'h0;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         msr_rsp_r <= '0;
      end else begin
         msr_rsp_r.ack   <= msr_req.req;
         msr_rsp_r.err   <= msr_req.req && !idx_ok;
         msr_rsp_r.rdata <= (msr_req.req && !msr_req.we) ? rd_sel : 64'h0;
      end
   end

   assign msr_rsp = msr_rsp_r;

   ////////////////////////////////////////////////////////////////////////
   // access classification
   wire logic [MIR_ARCH_PA_W-1:0] low_bound  =
      {low_top_r, {MIR_TOP_LSB{1'b0}}};
   wire logic [MIR_ARCH_PA_W-1:0] high_bound =
      {high_top_r, {MIR_TOP_LSB{1'b0}}};
   wire logic below_4g   = acc_addr < MIR_FOUR_GIG;
   wire logic low_mem    = acc_addr < low_bound;
   wire logic high_mem   = acc_addr < high_bound;
   wire logic low_apply  = below_4g && low_en_r;
   wire logic high_apply = !below_4g && high_en_r;

   // overlapping pairs: lowest numbered hit wins
   logic pair_any;
   logic pair_rd;
   logic pair_wr;
   always_comb begin
      pair_any = 1'b0;
      pair_rd  = 1'b0;
      pair_wr  = 1'b0;
      for (int i = MIR_NUM_PAIRS - 1; i >= 0; i--) begin
         if (pair_hit[i]) begin
            pair_any = 1'b1;
            pair_rd  = rdm_r[i];
            pair_wr  = wrm_r[i];
         end
      end
   end

   // pair hits take precedence over the top-of-memory regions
   wire mir_src_t src_nxt =
      pair_any   ? MIR_SRC_PAIR :
      low_apply  ? MIR_SRC_LOW_TOP :
      high_apply ? MIR_SRC_HIGH_TOP : MIR_SRC_DEFAULT;
   wire logic pair_mem = access.write ? pair_wr : pair_rd;
   wire logic top_mem  = low_apply ? low_mem : high_mem;
   wire logic mem_nxt  =
      (src_nxt == MIR_SRC_PAIR)    ? pair_mem :
      (src_nxt == MIR_SRC_DEFAULT) ? 1'b0 : top_mem;
   // top regions route reads and writes alike
   wire logic rd_eff = (src_nxt == MIR_SRC_PAIR) ? pair_rd : mem_nxt;
   wire logic wr_eff = (src_nxt == MIR_SRC_PAIR) ? pair_wr : mem_nxt;
   wire logic reserved_nxt =
      !mir_combo_ok(rd_eff, wr_eff, access.mtype);

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         route_r <= '0;
      end else begin
         route_r.valid          <= access.valid;
         route_r.to_memory      <= access.valid && mem_nxt;
         route_r.source         <= src_nxt;
         route_r.mtype          <= access.mtype;
         route_r.combo_reserved <= access.valid && reserved_nxt;
      end
   end

   assign route = route_r;

endmodule : mir_router
`default_nettype wire

//--- mir_router_monitor.sv
// port assertions for the memory/io range router
`timescale 1ns/1ps
`default_nettype none
module mir_router_monitor #(
   parameter int PA_W = 52
) (
   // clock and reset
   input wire logic                  clk,
   input wire logic                  rst_n,
   // register port
   input wire mir_pkg::mir_msr_req_t msr_req,
   input wire mir_pkg::mir_msr_rsp_t msr_rsp,
   // access path
   input wire mir_pkg::mir_access_t  access,
   input wire mir_pkg::mir_route_t   route
);
   import mir_pkg::*;
   // bits above the implemented width take no part in routing
   localparam logic [51:0] KEEP = {52{1'b1}} >> (52 - PA_W);
   logic [19:0] hi_r;
   logic [2:0]  mt_r;
   // upper address and type of the access answered this cycle
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         hi_r <= 20'h0;
         mt_r <= 3'h0;
      end else begin
         hi_r <= 20'((access.addr & KEEP) >> 32);
         mt_r <= access.mtype;
      end
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   a_ack_one_cycle: assert property (msr_req.req |=> msr_rsp.ack)
      else $error("register ack missing");
   a_no_stray_ack: assert property (!msr_req.req |=> !msr_rsp.ack)
      else $error("ack without request");
   a_err_unmapped: assert property (
      msr_req.req && msr_req.index >= 4'h7 |=> msr_rsp.err &&
      msr_rsp.rdata == 64'h0) else $error("unmapped");
   a_err_mapped: assert property (msr_req.req && msr_req.index < 4'h7
      |=> !msr_rsp.err) else $error("error on mapped register");
   a_rsvd_read_zero: assert property (msr_rsp.ack
      |-> msr_rsp.rdata[63:52] == 12'h0 && msr_rsp.rdata[2:0] == 3'h0)
      else $error("reserved bits read nonzero");
   a_idle_route: assert property (!access.valid |=> !route.valid &&
      !route.to_memory && !route.combo_reserved) else $error("idle route");
   a_type_copied: assert property (route.valid |->
      route.mtype == mt_r) else $error("memory type not carried");
   a_default_io: assert property (route.source == MIR_SRC_DEFAULT
      |-> !route.to_memory) else $error("default route not io");
   a_low_below_4g: assert property (route.valid &&
      route.source == MIR_SRC_LOW_TOP |-> hi_r == 20'h0)
      else $error("low top used above 4g");
   a_high_above_4g: assert property (route.valid &&
      route.source == MIR_SRC_HIGH_TOP |-> hi_r != 20'h0)
      else $error("high top used below 4g");
endmodule : mir_router_monitor
bind mir_router mir_router_monitor #(.PA_W(PA_W)) u_mir_router_monitor (
   .clk(clk), .rst_n(rst_n), .msr_req(msr_req), .msr_rsp(msr_rsp),
   .access(access), .route(route));
`default_nettype wire

//--- tb.sv
// self-checking bench for the memory/io range router
`timescale 1ns/1ps
`default_nettype none
module tb;
   import mir_pkg::*;
   logic         clk;
   logic         rst_n;
   mir_msr_req_t msr_req;
   mir_msr_rsp_t msr_rsp;
   mir_access_t  access;
   mir_route_t   route;
   logic [15:0]  n_mem;
   logic [15:0]  n_io;
   logic [64:0]  qr[$];
   logic [3:0]   qa[$];
   logic [63:0]  v;
   logic [2:0]   mtx;
   int           n_mismatch;
   int           checked;
   int           n_acc;
   int           cyc;
   int           seed;
   // reserved type bits per {read_from_memory, write_to_memory}
   localparam logic [7:0] RSV [4] = '{8'hcc, 8'hfc, 8'hde, 8'hac};
   localparam logic [63:0] RM [8] = '{64'h000f_ffff_ffff_f018,
      64'h000f_ffff_ffff_f800, 64'h000f_ffff_ffff_f018,
      64'h000f_ffff_ffff_f800, 64'h000f_ffff_ff80_0000,
      64'h000f_ffff_ff80_0000, 64'h0000_0000_0030_0000, 64'h0};
   mir_router #(.PA_W(52)) u_mir_router (.clk(clk), .rst_n(rst_n),
      .msr_req(msr_req), .msr_rsp(msr_rsp), .access(access), .route(route));
   mir_far_side u_mir_far_side (.clk(clk), .rst_n(rst_n), .route(route),
      .n_mem(n_mem), .n_io(n_io));
   task automatic chk(input string what, input logic [64:0] seen,
                      input logic [64:0] exp);
      checked++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("wrong value %s exp %h seen %h", what, exp, seen);
      end
   endtask : chk
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", checked, n_mismatch);
      if (n_mismatch == 0 && checked > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : give_verdict
   task automatic reg_op(input logic we, input logic [3:0] idx,
                         input logic [63:0] d, input logic [64:0] e);
      @(posedge clk);
      #1;
      msr_req = '{1'b1, we, idx, d};
      qr.push_back(e);
      @(posedge clk);
      #1;
      msr_req.req = 1'b0;
   endtask : reg_op
   task automatic acc(input logic w, input logic [51:0] a, input logic rdm,
                      input logic wrm, input logic [1:0] src);
      @(posedge clk);
      #1;
      access = '{1'b1, w, a, mtx};
      qa.push_back({w ? wrm : rdm, src, RSV[{rdm, wrm}][mtx]});
      n_acc++;
      mtx = 3'($random(seed));
      @(posedge clk);
      #1;
      access.valid = 1'b0;
   endtask : acc
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   // results are matched against the oldest note
   always @(posedge clk) begin
      #1;
      if (msr_rsp.ack === 1'b1)
         chk("register", {msr_rsp.err, msr_rsp.rdata}, qr.pop_front());
      if (route.valid === 1'b1)
         chk("route", 65'({route.to_memory, route.source,
             route.combo_reserved}), 65'(qa.pop_front()));
   end
   always @(posedge clk) begin
      cyc++;
      if (cyc == 5000) begin
         n_mismatch++;
         give_verdict();
      end
   end
   initial begin
      rst_n = 1'b0;
      msr_req = '0;
      access = '0;
      n_mismatch = 0;
      checked = 0;
      n_acc = 0;
      cyc = 0;
      seed = 54730;
      mtx = 3'h0;
      repeat (4) @(posedge clk);
      #1;
      rst_n = 1'b1;
      for (int i = 0; i < 7; i++) reg_op(1'b0, 4'(i), 64'h0, 65'h0);
      acc(1'b0, 52'h1000, 1'b0, 1'b0, MIR_SRC_DEFAULT);
      acc(1'b1, 52'hf_0000_0000_0000, 1'b0, 1'b0, MIR_SRC_DEFAULT);
      $display("test reset done");
      for (int i = 0; i < 8; i++) begin
         v = {$random(seed), $random(seed)};
         reg_op(1'b1, 4'(i), v, {i == 7, 64'h0});
         reg_op(1'b0, 4'(i), 64'h0, {i==7, v & RM[i]});
         reg_op(1'b1, 4'(i), 64'h0, {i == 7, 64'h0});
      end
      $display("test readback done");
      for (int p = 0; p < 2; p++)
         for (int k = 0; k < 4; k++) begin
            // pairs 16 megabytes apart never overlap
            v = 64'h1_2340_0000 + (64'(p) << 24);
            reg_op(1'b1, 4'(2*p), v | (64'(k) << 3), 65'h0);
            reg_op(1'b1, 4'(2*p+1), 64'h000f_ffff_ffff_0800, 65'h0);
            for (int t = 0; t < 8; t++) begin
               mtx = 3'(t);
               acc(t[0], v[51:0] + 52'(t * 'h1e01), k[1], k[0],
                   MIR_SRC_PAIR);
            end
            acc(1'b1, v[51:0] + 52'h1_0000, 1'b0, 1'b0,
                MIR_SRC_DEFAULT);
            reg_op(1'b1, 4'(2*p+1), 64'h000f_ffff_ffff_0000, 65'h0);
            acc(1'b0, v[51:0], 1'b0, 1'b0, MIR_SRC_DEFAULT);
         end
      $display("test pairs done");
      reg_op(1'b1, 4'h4, 64'h4080_0000, 65'h0);
      reg_op(1'b1, 4'h5, 64'h2_0080_0000, 65'h0);
      acc(1'b0, 52'h0, 1'b0, 1'b0, MIR_SRC_DEFAULT);
      acc(1'b1, 52'h1_0000_0000, 1'b0, 1'b0, MIR_SRC_DEFAULT);
      reg_op(1'b1, 4'h6, 64'h30_0000, 65'h0);
      acc(1'b0, 52'h0, 1'b1, 1'b1, MIR_SRC_LOW_TOP);
      acc(1'b1, 52'h407f_ffff, 1'b1, 1'b1, MIR_SRC_LOW_TOP);
      acc(1'b0, 52'h4080_0000, 1'b0, 1'b0, MIR_SRC_LOW_TOP);
      acc(1'b1, 52'hffff_ffff, 1'b0, 1'b0, MIR_SRC_LOW_TOP);
      acc(1'b0, 52'h1_0000_0000, 1'b1, 1'b1, MIR_SRC_HIGH_TOP);
      acc(1'b1, 52'h2_007f_ffff, 1'b1, 1'b1, MIR_SRC_HIGH_TOP);
      acc(1'b0, 52'h2_0080_0000, 1'b0, 1'b0, MIR_SRC_HIGH_TOP);
      acc(1'b1, 52'hf_ffff_ffff_ffff, 1'b0, 1'b0, MIR_SRC_HIGH_TOP);
      reg_op(1'b1, 4'h6, 64'h10_0000, 65'h0);
      acc(1'b0, 52'h1_0000_0000, 1'b0, 1'b0, MIR_SRC_DEFAULT);
      acc(1'b1, 52'h1000, 1'b1, 1'b1, MIR_SRC_LOW_TOP);
      // high top alone: the low region falls back to io
      reg_op(1'b1, 4'h6, 64'h20_0000, 65'h0);
      acc(1'b0, 52'h4000, 1'b0, 1'b0, MIR_SRC_DEFAULT);
      acc(1'b1, 52'h1_0000_1000, 1'b1, 1'b1, MIR_SRC_HIGH_TOP);
      $display("test tops done");
      repeat (3) @(posedge clk);
      chk("pending notes", 65'(qr.size() + qa.size()), 65'h0);
      chk("far side count", 65'(n_mem + n_io), 65'(n_acc));
      give_verdict();
   end
endmodule : tb
`default_nettype wire
